// file: bench/spi_dev_model.sv
`timescale 1ns/1ps
module spi_dev_model (
    input  wire logic       sck,
    input  wire logic       mosi,
    input  wire logic       sel_n,
    input  wire logic [1:0] mode,
    input  wire logic [7:0] load,
    output logic            miso,
    output logic [7:0]      shreg
);
    initial begin
        miso = 1'b0;
        shreg = 8'h00;
    end
    // Passive: moves only on the clock and the select it is given
    always @(negedge sel_n) begin
        shreg = load;
        if (!mode[0]) miso = shreg[7];
    end
    // Released line shows the opposite of its last level
    always @(posedge sel_n) miso = ~miso;
    always @(sck) begin
        if (!sel_n) begin
            if ((sck != mode[1]) ^ mode[0]) shreg = {shreg[6:0], mosi};
            else miso = shreg[7];
        end
    end
endmodule

// file: bench/spi_port_asserts.sv
`timescale 1ns/1ps
module spi_port_asserts (
    input wire logic                      sys_clk_i,
    input wire logic                      rst_i,
    input wire spi_port_pkg::bus_req_type bus_req_i,
    input wire logic [7:0]                rd_data_o,
    input wire logic                      sck_i,
    input wire logic                      sck_o,
    input wire logic                      sck_oe_o,
    input wire logic                      mosi_i,
    input wire logic                      mosi_o,
    input wire logic                      mosi_oe_o,
    input wire logic                      miso_i,
    input wire logic                      miso_o,
    input wire logic                      miso_oe_o,
    input wire logic                      ss_n_i,
    input wire logic                      xfer_busy_o,
    input wire logic                      transfer_done_o
);
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);
    logic       prev_sck;
    logic [4:0] tog;
    wire        dacc = (bus_req_i.wr || bus_req_i.rd) && bus_req_i.addr == spi_port_pkg::DATA_ADDR;
    // Clock toggles seen while busy
    always_ff @(posedge sys_clk_i) begin
        prev_sck <= sck_o;
        tog      <= (rst_i || !xfer_busy_o) ? 5'h00 : tog + 5'(sck_o != prev_sck);
    end
    a_rd_idle: assert property (!$past(bus_req_i.rd) |-> rd_data_o == 8'h00)
        else $error("read data outside answer");
    a_start_msb: assert property (dacc && bus_req_i.wr && sck_oe_o && !xfer_busy_o
        |=> xfer_busy_o && mosi_o == $past(bus_req_i.wdata[7])) else $error("bad start");
    a_eight_clk: assert property ($fell(xfer_busy_o) && sck_oe_o |-> tog == 5'h0f && sck_o != prev_sck)
        else $error("clock count wrong");
    a_done_end: assert property ($fell(xfer_busy_o) && (sck_oe_o || miso_oe_o) |-> transfer_done_o)
        else $error("done not set");
    a_clk_idle: assert property (sck_oe_o && $past(sck_oe_o) && !xfer_busy_o && !$past(xfer_busy_o)
        && !$past(bus_req_i.wr) |-> $stable(sck_o)) else $error("idle clock moved");
    a_master_pins: assert property (sck_oe_o |-> mosi_oe_o && !miso_oe_o)
        else $error("master pin drive wrong");
    a_slave_sel: assert property (miso_oe_o |-> !$past(ss_n_i) && !sck_oe_o)
        else $error("slave drive without select");
    a_done_clear: assert property ($fell(transfer_done_o) |-> $past(dacc))
        else $error("done cleared early");
    a_fault_off: assert property (sck_oe_o && !ss_n_i |=> !sck_oe_o && !mosi_oe_o)
        else $error("master kept driving on select fault");
    c_master: cover property ($fell(xfer_busy_o) && sck_oe_o);
    c_fault: cover property (sck_oe_o && !ss_n_i);
    c_slave: cover property ($fell(xfer_busy_o) && miso_oe_o);
    c_coll: cover property (dacc && bus_req_i.wr && xfer_busy_o);
endmodule
bind spi_port spi_port_asserts u_spi_port_asserts (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
    .bus_req_i(bus_req_i), .rd_data_o(rd_data_o), .sck_i(sck_i), .sck_o(sck_o), .sck_oe_o(sck_oe_o),
    .mosi_i(mosi_i), .mosi_o(mosi_o), .mosi_oe_o(mosi_oe_o), .miso_i(miso_i), .miso_o(miso_o),
    .miso_oe_o(miso_oe_o), .ss_n_i(ss_n_i), .xfer_busy_o(xfer_busy_o), .transfer_done_o(transfer_done_o));

// file: bench/tb_spi_port.sv
`timescale 1ns/1ps
module tb_spi_port;
    logic                      sys_clk_i;
    logic                      rst_i;
    spi_port_pkg::bus_req_type req;
    logic [7:0]                rd_data_o, dev_load, dev_shreg;
    logic [1:0]                dev_mode;
    logic                      sck_o, sck_oe_o, mosi_o, mosi_oe_o, miso_o, miso_oe_o, busy, done;
    logic                      ss_n, sck_in, mosi_in, dev_sel_n, dev_miso;
    int                        err_total, comparisons, cycles;
    int                        half [4] = '{1, 2, 8, 16};
    always #5 sys_clk_i = ~sys_clk_i;
    spi_port u_spi_port (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .bus_req_i(req), .rd_data_o(rd_data_o),
        .sck_i(sck_oe_o ? sck_o : sck_in), .sck_o(sck_o), .sck_oe_o(sck_oe_o),
        .mosi_i(mosi_oe_o ? mosi_o : mosi_in), .mosi_o(mosi_o), .mosi_oe_o(mosi_oe_o),
        .miso_i(miso_oe_o ? miso_o : dev_miso), .miso_o(miso_o), .miso_oe_o(miso_oe_o),
        .ss_n_i(ss_n), .xfer_busy_o(busy), .transfer_done_o(done));
    spi_dev_model u_spi_dev_model (.sck(sck_o), .mosi(mosi_o), .sel_n(dev_sel_n), .mode(dev_mode),
        .load(dev_load), .miso(dev_miso), .shreg(dev_shreg));
    task automatic tick(input int k);
        repeat (k) @(posedge sys_clk_i);
        #1;
    endtask
    task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic end_of_test;
        $display("comparisons %0d err_total %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        tick(1);
        req.wr <= 1'b0;
        tick(1);
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] q);
        req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        tick(1);
        q = rd_data_o;
        req.rd <= 1'b0;
        tick(1);
    endtask
    task automatic reset_check;
        logic [7:0] q;
        chk("pin enables", {5'h00, sck_oe_o, mosi_oe_o, miso_oe_o}, 8'h00);
        rd(spi_port_pkg::CTRL_ADDR, q);
        chk("control reset", q, 8'h00);
        rd(spi_port_pkg::STAT_ADDR, q);
        chk("status reset", q, 8'h00);
        rd(8'h3f, q);
        chk("unmapped", q, 8'h00);
        wr(spi_port_pkg::DATA_ADDR, 8'h77);
        chk("port off write", busy, 1'b0);
        wr(spi_port_pkg::CTRL_ADDR, 8'hff);
        rd(spi_port_pkg::CTRL_ADDR, q);
        chk("control bits", q, 8'hdf);
        chk("master drive", {sck_oe_o, mosi_oe_o, miso_oe_o}, 8'h06);
    endtask
    task automatic master_xfer(input logic [1:0] m, input logic [1:0] r, input logic [7:0] tx,
                               input logic [7:0] rx, input logic coll);
        int n, first, last;
        logic prev;
        logic [7:0] q;
        first = 0;
        last = 0;
        wr(spi_port_pkg::CTRL_ADDR, {4'h5, m, r});
        chk("sck idle", sck_o, m[1]);
        dev_mode = m;
        dev_load = rx;
        dev_sel_n <= 1'b0;
        req <= '{addr: spi_port_pkg::DATA_ADDR, wdata: tx, wr: 1'b1, rd: 1'b0};
        prev = m[1];
        for (n = 0; n < 600; n++) begin
            tick(1);
            req.wr <= coll && n == 4;
            if (n == 0) req.wdata <= ~tx;
            if (sck_o !== prev) begin
                if (first == 0) first = n;
                last = n;
            end
            prev = sck_o;
            if (busy !== 1'b1) break;
        end
        tick(1);
        chk("sck span", 8'(last - first), 8'(15 * half[r]));
        chk("sck rest", sck_o, m[1]);
        chk("far end", dev_shreg, tx);
        dev_sel_n <= 1'b1;
        rd(spi_port_pkg::STAT_ADDR, q);
        chk("status", q, {1'b1, coll, 6'h00});
        rd(spi_port_pkg::DATA_ADDR, q);
        chk("read buffer", q, rx);
        chk("done clear", done, 1'b0);
    endtask
    // Select pulled low on an enabled master: port drops master mode and releases pins
    task automatic fault_check;
        logic [7:0] q;
        wr(spi_port_pkg::CTRL_ADDR, 8'h50);
        ss_n <= 1'b0;
        tick(2);
        ss_n <= 1'b1;
        chk("fault release", {sck_oe_o, mosi_oe_o, miso_oe_o}, 8'h00);
        rd(spi_port_pkg::CTRL_ADDR, q);
        chk("fault control", q, 8'h00);
        rd(spi_port_pkg::STAT_ADDR, q);
        chk("fault status", q, 8'h10);
        wr(spi_port_pkg::CTRL_ADDR, 8'h00);
        rd(spi_port_pkg::STAT_ADDR, q);
        chk("fault clear", q, 8'h00);
    endtask
    task automatic slave_xfer;
        logic [7:0] got, q;
        wr(spi_port_pkg::CTRL_ADDR, 8'h40);
        wr(spi_port_pkg::DATA_ADDR, 8'h3c);
        ss_n <= 1'b0;
        tick(3);
        chk("slave drive", {sck_oe_o, miso_oe_o}, 8'h01);
        for (int b = 7; b >= 0; b--) begin
            mosi_in <= 1'(8'ha5 >> b);
            tick(3);
            got[b] = miso_o;
            sck_in <= 1'b1;
            tick(3);
            sck_in <= 1'b0;
        end
        tick(4);
        chk("slave out", got, 8'h3c);
        chk("slave done", done, 1'b1);
        rd(spi_port_pkg::DATA_ADDR, q);
        chk("slave in", q, 8'ha5);
        chk("done kept", done, 1'b1);
        ss_n <= 1'b1;
        tick(2);
        chk("deselect", miso_oe_o, 1'b0);
    endtask
    always @(posedge sys_clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            err_total++;
            end_of_test();
        end
    end
    initial begin
        sys_clk_i = 1'b0;
        rst_i = 1'b1;
        req = '0;
        {ss_n, dev_sel_n, sck_in, mosi_in, dev_mode, dev_load} = {2'b11, 12'h000};
        repeat (8) @(posedge sys_clk_i);
        rst_i <= 1'b0;
        tick(1);
        reset_check();
        for (int i = 0; i < 4; i++) master_xfer(2'(i), 2'(i), 8'hc3 ^ 8'(i), 8'h5a ^ 8'(i << 4), i == 3);
        fault_check();
        slave_xfer();
        end_of_test();
    end
endmodule

// file: rtl/spi_port.sv
`timescale 1ns/1ps
// Contract
// (R1) Shift eight bits out while eight in
// (R2) Both shift registers form one 16-bit ring
// (R3) Pins undriven while port not in use
// (R4) Master data write starts transfer, processor clock
// (R5) Written byte loads shifter, shifts out serially
// (R6) After eighth shift copy into read buffer
// (R7) Set done flag when transfer finishes
// (R8) Most significant bit first, least last
// (R9) Master in on MISO, slave out on MISO
// (R10) Master select is control bit 4
// (R11) Polarity and phase give four timings
// (R12) Phase picks one of two protocols
// (R13) Clock pin output as master, input slave
// (R14) Master makes exactly eight clock cycles
// (R15) Change on one edge, sample opposite edge
// (R16) Two rate bits in control register 0x0a
// (R17) Four master rates, slave rate limited
// (R18) Both ends use matching polarity and phase
// (R19) Select low enables slave transfer
// (R20) Select held high on a master
// (R21) Slave never starts a transfer itself
// (R22) Write collision and end-of-transfer flags
// (R23) Rate codes divide by 2,4,16,32
// (R24) Clock idles at polarity level
// (R25) Write during transfer sets collision, discarded
// (R26) Status read then data access clears done
module spi_port (
    input  wire logic                      sys_clk_i,
    input  wire logic                      rst_i,
    input  wire spi_port_pkg::bus_req_type bus_req_i,
    output logic [7:0]                     rd_data_o,
    input  wire logic                      sck_i,
    output logic                           sck_o,
    output logic                           sck_oe_o,
    input  wire logic                      mosi_i,
    output logic                           mosi_o,
    output logic                           mosi_oe_o,
    input  wire logic                      miso_i,
    output logic                           miso_o,
    output logic                           miso_oe_o,
    input  wire logic                      ss_n_i,
    output logic                           xfer_busy_o,
    output logic                           transfer_done_o
);
    spi_port_pkg::port_state_type r;
    spi_port_pkg::port_state_type next_r;

    logic       rate_tick;
    logic       enabled;
    logic       is_master;
    logic       is_slave_sel;
    logic       clock_polarity_bit;
    logic       clock_phase_bit;
    logic [1:0] rate;
    logic       busy;
    logic       data_in;
    logic       edge_now;
    logic       slave_edge;
    logic       leading;
    logic       sample_edge;
    logic       shift_edge;
    logic [7:0] final_byte;
    logic       wr_ctrl;
    logic       wr_data;
    logic       rd_stat;
    logic       rd_data;

    assign enabled      = r.ctrl[spi_port_pkg::CTRL_ENABLE_BIT];
    assign is_master    = enabled && r.ctrl[spi_port_pkg::CTRL_MASTER_BIT]; // see (R10)
    assign is_slave_sel = enabled && !r.ctrl[spi_port_pkg::CTRL_MASTER_BIT] && !ss_n_i; // see (R19)
    assign clock_polarity_bit         = r.ctrl[spi_port_pkg::CTRL_CLOCK_POLARITY_BIT_BIT]; // see (R11) (R18)
    assign clock_phase_bit         = r.ctrl[spi_port_pkg::CTRL_CLOCK_PHASE_BIT_BIT];
    assign rate         = r.ctrl[spi_port_pkg::CTRL_RATE_HI:spi_port_pkg::CTRL_RATE_LO]; // see (R16)
    assign busy         = (r.state == spi_port_pkg::XFER_SHIFT);

    assign wr_ctrl = bus_req_i.wr && (bus_req_i.addr == spi_port_pkg::CTRL_ADDR);
    assign wr_data = bus_req_i.wr && (bus_req_i.addr == spi_port_pkg::DATA_ADDR);
    assign rd_stat = bus_req_i.rd && (bus_req_i.addr == spi_port_pkg::STAT_ADDR);
    assign rd_data = bus_req_i.rd && (bus_req_i.addr == spi_port_pkg::DATA_ADDR);

    // Rate codes only matter while this end owns the clock
    spi_rate_divider u_divider (
        .sys_clk_i (sys_clk_i),
        .rst_i     (rst_i),
        .run_i     (is_master && busy), // see (R4) (R17) (R23)
        .rate_i    (rate),
        .tick_o    (rate_tick)
    );

    always_comb begin
        // Master samples the slave output, slave samples the master output
        data_in = is_master ? miso_i : mosi_i; // see (R9)

        // Slave edges come from the far clock, only while selected
        slave_edge = is_slave_sel && (sck_i != r.sck_prev); // see (R13) (R21)
        edge_now   = is_master ? (busy && rate_tick) : slave_edge;

        // Even edge numbers are leading edges, odd ones trailing
        leading     = !r.edge_cnt[0];
        sample_edge = clock_phase_bit ? !leading : leading; // see (R12) (R15)
        shift_edge  = clock_phase_bit ? (leading && (r.edge_cnt != 4'h0)) : !leading; // see (R11) (R15)

        // Last bit enters through the sample latch or straight from the pin
        final_byte = clock_phase_bit ? {r.shreg[6:0], data_in} : {r.shreg[6:0], r.sample}; // see (R8)
    end

    always_comb begin
        next_r          = r;
        next_r.rd_data  = 8'h00;
        next_r.sck_prev = sck_i;

        // Register reads: data stands for one cycle only
        if (rd_stat) begin
            next_r.rd_data[spi_port_pkg::STAT_DONE_BIT] = r.done;
            next_r.rd_data[spi_port_pkg::STAT_WRITE_COLLISION_FLAG_BIT] = r.write_collision_flag;
            next_r.rd_data[spi_port_pkg::STAT_MODF_BIT] = r.modf;
            next_r.flag_armed = r.done || r.write_collision_flag; // see (R26)
            next_r.modf_armed = r.modf;
        end
        if (bus_req_i.rd && (bus_req_i.addr == spi_port_pkg::CTRL_ADDR)) begin
            next_r.rd_data = r.ctrl;
        end
        if (rd_data) begin
            next_r.rd_data = r.rx_buf; // see (R6)
        end

        // Status read followed by a data access clears the done and collision flags
        if ((rd_data || wr_data) && r.flag_armed) begin
            next_r.done       = 1'b0; // see (R26)
            next_r.write_collision_flag       = 1'b0;
            next_r.flag_armed = 1'b0;
        end

        // Control write, reserved bit stays zero
        if (wr_ctrl) begin
            next_r.ctrl = bus_req_i.wdata & spi_port_pkg::CTRL_WRITE_MASK;
            if (r.modf_armed) begin
                next_r.modf       = 1'b0;
                next_r.modf_armed = 1'b0;
            end
        end

        // Data write: load when idle, collide when busy
        if (wr_data && enabled) begin
            if (busy) begin
                next_r.write_collision_flag = 1'b1; // see (R22) (R25)
            end else begin
                next_r.shreg = bus_req_i.wdata; // see (R5)
                if (is_master) begin
                    next_r.state    = spi_port_pkg::XFER_SHIFT; // see (R4)
                    next_r.edge_cnt = 4'h0;
                    next_r.sck      = clock_polarity_bit;
                end
            end
        end

        // Slave joins on the first edge while selected
        if (!busy && slave_edge && !wr_data) begin
            next_r.state    = spi_port_pkg::XFER_SHIFT; // see (R21)
            next_r.edge_cnt = 4'h0;
        end

        // Serial edge processing
        if (edge_now && (busy || !is_master)) begin
            next_r.edge_cnt = r.edge_cnt + 4'h1;
            if (is_master) begin
                next_r.sck = !r.sck; // see (R14)
            end
            if (sample_edge) begin
                next_r.sample = data_in; // see (R1) (R15)
            end
            if (shift_edge) begin
                next_r.shreg = {r.shreg[6:0], r.sample}; // see (R2) (R8)
            end
            if (r.edge_cnt == spi_port_pkg::LAST_EDGE) begin
                next_r.shreg  = final_byte; // see (R2)
                next_r.rx_buf = final_byte; // see (R6)
                next_r.done   = 1'b1; // see (R7) (R22)
                next_r.state  = spi_port_pkg::XFER_IDLE;
            end
        end

        // Deselect aborts an unfinished slave transfer
        if (!is_master && !is_slave_sel) begin
            next_r.state    = spi_port_pkg::XFER_IDLE;
            next_r.edge_cnt = 4'h0;
        end

        // Select driven low on a master is a mode fault
        if (is_master && !ss_n_i) begin
            next_r.modf = 1'b1; // see (R20)
            next_r.ctrl[spi_port_pkg::CTRL_MASTER_BIT] = 1'b0;
            next_r.ctrl[spi_port_pkg::CTRL_ENABLE_BIT] = 1'b0;
            next_r.state    = spi_port_pkg::XFER_IDLE;
            next_r.edge_cnt = 4'h0;
        end

        // Port off: drop any transfer in flight
        if (!enabled) begin
            next_r.state    = spi_port_pkg::XFER_IDLE;
            next_r.edge_cnt = 4'h0;
        end

        // Clock rests at the polarity level outside transfers
        if (next_r.state == spi_port_pkg::XFER_IDLE) begin
            next_r.sck = next_r.ctrl[spi_port_pkg::CTRL_CLOCK_POLARITY_BIT_BIT]; // see (R24)
        end

        // Pin drivers
        next_r.sck_oe  = next_r.ctrl[spi_port_pkg::CTRL_ENABLE_BIT]
                         && next_r.ctrl[spi_port_pkg::CTRL_MASTER_BIT]; // see (R3) (R13)
        next_r.mosi_oe = next_r.sck_oe; // see (R9) (R10)
        next_r.miso_oe = next_r.ctrl[spi_port_pkg::CTRL_ENABLE_BIT]
                         && !next_r.ctrl[spi_port_pkg::CTRL_MASTER_BIT] && !ss_n_i; // see (R3) (R9) (R19)
        next_r.mosi    = next_r.shreg[7]; // see (R8)
        next_r.miso    = next_r.shreg[7];
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            r        <= '0;
            r.ctrl   <= spi_port_pkg::CTRL_RESET;
            r.shreg  <= spi_port_pkg::DATA_RESET;
            r.rx_buf <= spi_port_pkg::DATA_RESET;
            r.state  <= spi_port_pkg::XFER_IDLE;
        end else begin
            r <= next_r;
        end
    end

    assign rd_data_o       = r.rd_data;
    assign sck_o           = r.sck;
    assign sck_oe_o        = r.sck_oe;
    assign mosi_o          = r.mosi;
    assign mosi_oe_o       = r.mosi_oe;
    assign miso_o          = r.miso;
    assign miso_oe_o       = r.miso_oe;
    assign xfer_busy_o     = busy;
    assign transfer_done_o = r.done;
endmodule

// file: rtl/spi_port_pkg.sv
package spi_port_pkg;

    // Register offsets
    localparam logic [7:0] CTRL_ADDR = 8'h0a;
    localparam logic [7:0] STAT_ADDR = 8'h0b;
    localparam logic [7:0] DATA_ADDR = 8'h0c;

    // Control register field positions
    localparam int CTRL_IRQ_EN_BIT = 7;
    localparam int CTRL_ENABLE_BIT = 6;
    localparam int CTRL_MASTER_BIT = 4;
    localparam int CTRL_CLOCK_POLARITY_BIT_BIT   = 3;
    localparam int CTRL_CLOCK_PHASE_BIT_BIT   = 2;
    localparam int CTRL_RATE_HI    = 1;
    localparam int CTRL_RATE_LO    = 0;
    localparam logic [7:0] CTRL_WRITE_MASK = 8'hdf;

    // Status register field positions
    localparam int STAT_DONE_BIT = 7;
    localparam int STAT_WRITE_COLLISION_FLAG_BIT = 6;
    localparam int STAT_MODF_BIT = 4;

    // Reset values
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] DATA_RESET = 8'h00;

    // Serial clock edges per character, numbered 0 to 15
    localparam logic [3:0] LAST_EDGE = 4'hf;

    // Master clock divisors of the processor clock per rate code
    localparam logic [5:0] DIV_RATE0 = 6'h02;
    localparam logic [5:0] DIV_RATE1 = 6'h04;
    localparam logic [5:0] DIV_RATE2 = 6'h10;
    localparam logic [5:0] DIV_RATE3 = 6'h20;

    // Reload value of the half-period counter for one rate code
    function automatic logic [3:0] half_reload(input logic [1:0] rate);
        logic [5:0] div;
        div = DIV_RATE0;
        unique case (rate)
            2'h0: div = DIV_RATE0;
            2'h1: div = DIV_RATE1;
            2'h2: div = DIV_RATE2;
            2'h3: div = DIV_RATE3;
        endcase
        return div[4:1] - 4'h1;
    endfunction

    typedef enum logic {XFER_IDLE, XFER_SHIFT} xfer_state_type;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } bus_req_type;

    typedef struct packed {
        logic [3:0] cnt;
    } div_state_type;

    typedef struct packed {
        logic [7:0]     ctrl;
        logic           done;
        logic           write_collision_flag;
        logic           modf;
        logic           flag_armed;
        logic           modf_armed;
        logic [7:0]     rx_buf;
        logic [7:0]     shreg;
        logic           sample;
        xfer_state_type state;
        logic [3:0]     edge_cnt;
        logic           sck_prev;
        logic           sck;
        logic           sck_oe;
        logic           mosi;
        logic           mosi_oe;
        logic           miso;
        logic           miso_oe;
        logic [7:0]     rd_data;
    } port_state_type;

endpackage

// file: rtl/spi_rate_divider.sv
`timescale 1ns/1ps
module spi_rate_divider (
    input  wire logic       sys_clk_i,
    input  wire logic       rst_i,
    input  wire logic       run_i,
    input  wire logic [1:0] rate_i,
    output logic            tick_o
);
    spi_port_pkg::div_state_type r;
    spi_port_pkg::div_state_type next_r;

    always_comb begin
        next_r = r;
        tick_o = 1'b0;
        if (!run_i) begin
            next_r.cnt = spi_port_pkg::half_reload(rate_i);
        end else if (r.cnt == 4'h0) begin
            tick_o     = 1'b1; // see (R23)
            next_r.cnt = spi_port_pkg::half_reload(rate_i);
        end else begin
            next_r.cnt = r.cnt - 4'h1;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end
endmodule
